//--- pmc_cfg_cmd.v
// command handler for fault-log, driver-pin and margin-converter settings
//
// Operation
// - bit 0 switches cyclic fault logging, rest zero
// - pin index 0-15 selects pin, 0xff all
// - pin readback length 2 single, 32 all
// - pin block write count 3 to 33
// - pin writes run upward from starting index
// - bits 15:13 set pin operating mode
// - bits 12:9 set input glitch filter width
// - bits 2:0 choose output driver type
// - weak pull-downs active from reset onward
// - converter index 0-8 selects one, 0xff all
// - converter readback length 2 single, 18 all
// - converter block write count 3 to 19
// - converter writes run upward from starting index
// - bits 10:6 pick closed-loop supervised input
// - bit 5 stops loop at setpoint
// - bits 1:0 select margin mode
// - converter bits 15:11 read zero always
`timescale 1ns/10ps
`include "pmc_map.vh"
module pmc_cfg_cmd #(
  parameter NPIN   = `PMC_PIN_COUNT,
  parameter NCONV  = `PMC_CONV_COUNT,
  parameter CLK_NS = `PMC_CLK_NS,
  parameter CNT_W  = 17
) (
  input  wire               sys_clk,
  input  wire               sys_rst,
  input  wire               cmd_valid,
  input  wire [7:0]         cmd_code,
  input  wire               wr_valid,
  input  wire [7:0]         wr_data,
  input  wire               xfer_end,
  input  wire               rd_req,
  output reg                rd_valid,
  output reg  [7:0]         rd_data,
  input  wire               seq_active,
  input  wire [NPIN-1:0]    drv_level,
  input  wire [NPIN-1:0]    pin_in,
  output reg  [NPIN-1:0]    pin_out,
  output reg  [NPIN-1:0]    pin_oe,
  output reg  [NPIN-1:0]    pin_pull_up,
  output reg  [NPIN-1:0]    pin_pull_down,
  output reg  [NPIN-1:0]    pin_in_filt,
  output reg                cyclic_record,
  output wire [NCONV*2-1:0] margin_mode,
  output wire [NCONV*5-1:0] margin_source_select,
  output wire [NCONV-1:0]   margin_loop_stop
);

  ////////////////////////////////////////////////////////////////////////
  // transaction states
  localparam [2:0] ST_IDLE = 3'b001;   // no command open
  localparam [2:0] ST_WR   = 3'b010;   // taking written bytes
  localparam [2:0] ST_RD   = 3'b100;   // returning read bytes

  reg  [2:0]  state_q;     // one-hot transaction state
  reg  [7:0]  cmd_q;       // command of the open transaction
  reg  [7:0]  wcnt_q;      // written bytes so far, saturating
  reg  [7:0]  count_q;     // leading byte count
  reg  [7:0]  lo_q;        // low byte of a word in flight
  reg  [4:0]  wptr_q;      // next element to write
  reg         wok_q;       // block write passed its checks
  reg  [7:0]  idx_q;       // readback index byte
  reg         rb_ok_q;     // readback was set up with length 1
  reg  [7:0]  rcnt_q;      // bytes returned so far

  wire        is_pin  = (cmd_q == `PMC_CMD_PIN);
  wire        is_conv = (cmd_q == `PMC_CMD_CONV);
  wire        is_blk  = is_pin | is_conv;
  wire [7:0]  wr_max  = is_pin ? `PMC_PIN_WR_MAX : `PMC_CONV_WR_MAX;
  wire [8:0]  n_elem  = is_pin ? NPIN[8:0] : NCONV[8:0];
  wire [8:0]  n_words = {2'b00, count_q[7:1]} - {8'h00, ~count_q[0]};
  wire [8:0]  w_end   = {1'b0, wr_data} + n_words;
  wire        word_in = is_blk && wok_q && (wcnt_q >= 8'h03) && wcnt_q[0]
                        && (wcnt_q <= count_q);

  // byte that completes a word
  wire [15:0] new_word = {wr_data, lo_q};
  wire        pin_we   = wr_valid && (state_q == ST_WR) && is_pin && word_in;
  wire        conv_we  = wr_valid && (state_q == ST_WR) && is_conv && word_in;

  ////////////////////////////////////////////////////////////////////////
  // command, byte count, index and word assembly
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q       <= ST_IDLE;
      cmd_q         <= 8'h00;
      wcnt_q        <= 8'h00;
      count_q       <= 8'h00;
      lo_q          <= 8'h00;
      wptr_q        <= 5'h00;
      wok_q         <= 1'b0;
      idx_q         <= 8'h00;
      rb_ok_q       <= 1'b0;
      cyclic_record <= `PMC_FAULT_RST;
    end
    else if (cmd_valid)
    begin
      // a new command restarts the byte accounting
      state_q <= ST_WR;
      cmd_q   <= cmd_code;
      wcnt_q  <= 8'h00;
      wok_q   <= 1'b0;
      rb_ok_q <= 1'b0;
    end
    else if (xfer_end)
    begin
      state_q <= ST_IDLE;
    end
    else if (rd_req && (state_q != ST_IDLE))
    begin
      state_q <= ST_RD;
    end
    else if (wr_valid && (state_q == ST_WR))
    begin
      if (wcnt_q != 8'hff)
        wcnt_q <= wcnt_q + 8'h01;
      if (cmd_q == `PMC_CMD_FAULT_LOG)
      begin
        // word writes arrive low byte first; only bit 0 is stored
        if (wcnt_q == 8'h00)
          lo_q <= wr_data;
        else if (wcnt_q == 8'h01)
          cyclic_record <= lo_q[`PMC_CYCLIC_BIT];
      end
      else if (wcnt_q == 8'h00)
      begin
        count_q <= wr_data;
      end
      else if (wcnt_q == 8'h01)
      begin
        idx_q   <= wr_data;
        wptr_q  <= wr_data[4:0];
        // a length of 1 means the index selects what to read back
        rb_ok_q <= (count_q == `PMC_RDBK_PLEN);
        // out-of-range count or overrun of the last element blocks the write
        wok_q   <= (count_q >= `PMC_WR_MIN) && (count_q <= wr_max)
                   && (w_end <= n_elem);
      end
      else if (!wcnt_q[0])
      begin
        lo_q <= wr_data;
      end
      else if (word_in)
      begin
        wptr_q <= wptr_q + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration storage
  wire [15:0]         pin_rd_word;
  wire [15:0]         conv_rd_word;
  wire [NPIN*16-1:0]  pin_words;
  wire [NCONV*16-1:0] conv_words;
  wire [7:0]          rd_k;
  wire [3:0]          rd_addr;

  // readback word address walks the bank when all elements were asked for
  assign rd_k    = rcnt_q - 8'h01;
  assign rd_addr = (idx_q == `PMC_IDX_ALL) ? rd_k[4:1] : idx_q[3:0];

  pmc_cfg_bank #(
    .COUNT (NPIN),
    .AW    (4),
    .WMASK (`PMC_PIN_WMASK),
    .RST   (`PMC_PIN_RST)
  ) u_pin_bank (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .wr_en     (pin_we),
    .wr_addr   (wptr_q[3:0]),
    .wr_word   (new_word),
    .rd_addr   (rd_addr),
    .rd_word   (pin_rd_word),
    .all_words (pin_words)
  );

  // reserved upper bits are masked so they stay zero
  pmc_cfg_bank #(
    .COUNT (NCONV),
    .AW    (4),
    .WMASK (`PMC_CONV_WMASK),
    .RST   (`PMC_CONV_RST)
  ) u_conv_bank (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .wr_en     (conv_we),
    .wr_addr   (wptr_q[3:0]),
    .wr_word   (new_word),
    .rd_addr   (rd_addr),
    .rd_word   (conv_rd_word),
    .all_words (conv_words)
  );

  ////////////////////////////////////////////////////////////////////////
  // readback: for pin and converter commands byte 0 is the length, then words low byte first; fault log returns its word low byte first
  reg [7:0]  rd_len;    // length byte of this readback
  reg [15:0] rd_word;   // word holding the byte asked for
  reg [7:0]  rd_byte;   // byte to return

  always @*
  begin
    rd_len  = 8'h00;
    rd_word = 16'h0000;
    rd_byte = 8'h00;
    if (is_pin && rb_ok_q)
    begin
      if (idx_q == `PMC_IDX_ALL)
        rd_len = `PMC_PIN_RD_ALL;
      else if (idx_q < NPIN)
        rd_len = `PMC_RD_ONE;
      rd_word = pin_rd_word;
    end
    else if (is_conv && rb_ok_q)
    begin
      if (idx_q == `PMC_IDX_ALL)
        rd_len = `PMC_CONV_RD_ALL;
      else if (idx_q < NCONV)
        rd_len = `PMC_RD_ONE;
      rd_word = conv_rd_word;
    end
    if (cmd_q == `PMC_CMD_FAULT_LOG)
    begin
      // upper fifteen bits always read zero
      if (rcnt_q == 8'h00)
        rd_byte = {7'h00, cyclic_record};
    end
    else if (rcnt_q == 8'h00)
      rd_byte = rd_len;
    else if (rd_k < rd_len)
      rd_byte = rd_k[0] ? rd_word[15:8] : rd_word[7:0];
  end

  // answer one cycle after each request made while a command is open, unless a stop or a new command comes in the same cycle
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
      rcnt_q   <= 8'h00;
    end
    else
    begin
      rd_valid <= 1'b0;
      if (cmd_valid)
        rcnt_q <= 8'h00;
      else if (rd_req && (state_q != ST_IDLE) && !xfer_end)
      begin
        rd_valid <= 1'b1;
        rd_data  <= rd_byte;
        if (rcnt_q != 8'hff)
          rcnt_q <= rcnt_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // filter width lookup: least time, so cycles round up
  function [CNT_W-1:0] filt_cycles;
    input [3:0] code;
    reg   [31:0] ns;
    reg   [31:0] cyc;
    begin
      case (code)
        4'h0:    ns = `PMC_FILT_NS_0;
        4'h1:    ns = `PMC_FILT_NS_1;
        4'h2:    ns = `PMC_FILT_NS_2;
        4'h3:    ns = `PMC_FILT_NS_3;
        4'h4:    ns = `PMC_FILT_NS_4;
        4'h5:    ns = `PMC_FILT_NS_5;
        4'h6:    ns = `PMC_FILT_NS_6;
        4'h7:    ns = `PMC_FILT_NS_7;
        4'h8:    ns = `PMC_FILT_NS_8;
        4'h9:    ns = `PMC_FILT_NS_9;
        4'ha:    ns = `PMC_FILT_NS_10;
        4'hb:    ns = `PMC_FILT_NS_11;
        4'hc:    ns = `PMC_FILT_NS_12;
        4'hd:    ns = `PMC_FILT_NS_13;
        4'he:    ns = `PMC_FILT_NS_14;
        default: ns = `PMC_FILT_NS_15;
      endcase
      cyc = (ns + CLK_NS - 1) / CLK_NS;
      if (cyc == 0)
        cyc = 1;
      filt_cycles = cyc[CNT_W-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // per-pin filter and driver stage
  genvar p;
  generate
    for (p = 0; p < NPIN; p = p + 1)
    begin : g_pin
      wire [15:0] w    = pin_words[p*16 +: 16];
      wire [2:0]  mode = w[`PMC_PIN_MODE_HI:`PMC_PIN_MODE_LO];
      wire [2:0]  drv  = w[`PMC_PIN_DRV_HI:`PMC_PIN_DRV_LO];
      // output modes drive only once sequencing is running; codes 0,2,4-7 disable
      wire        o_en = seq_active &&
                         ((mode == `PMC_MODE_OUT) || (mode == `PMC_MODE_INOUT));
      wire        i_en = (mode == `PMC_MODE_IN) || (mode == `PMC_MODE_INOUT);
      wire        lvl  = drv_level[p];
      wire        filt;

      pmc_pulse_filter #(
        .CNT_W (CNT_W)
      ) u_filt (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .raw_in      (pin_in[p]),
        .hold_cycles (filt_cycles(w[`PMC_PIN_FILT_HI:`PMC_PIN_FILT_LO])),
        .clean_q     (filt)
      );

      // driver decode; weak pulls ignore mode and sequencing state
      always @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          pin_out[p]       <= 1'b0;
          pin_oe[p]        <= 1'b0;
          pin_pull_up[p]   <= 1'b0;
          pin_pull_down[p] <= 1'b1;
          pin_in_filt[p]   <= 1'b0;
        end
        else
        begin
          pin_in_filt[p]   <= i_en & filt;
          pin_pull_down[p] <= (drv == `PMC_DRV_WEAK_PD) ||
                              ((drv == `PMC_DRV_OS_PD) && o_en);
          pin_pull_up[p]   <= (drv == `PMC_DRV_WEAK_PU) ||
                              ((drv == `PMC_DRV_OD_PU) && o_en);
          case (drv)
            `PMC_DRV_PP:
            begin
              pin_out[p] <= lvl;
              pin_oe[p]  <= o_en;
            end
            `PMC_DRV_OD, `PMC_DRV_OD_PU:
            begin
              pin_out[p] <= 1'b0;
              pin_oe[p]  <= o_en & ~lvl;
            end
            `PMC_DRV_OS, `PMC_DRV_OS_PD:
            begin
              pin_out[p] <= 1'b1;
              pin_oe[p]  <= o_en & lvl;
            end
            default:
            begin
              // weak pulls and high impedance never drive
              pin_out[p] <= 1'b0;
              pin_oe[p]  <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // converter fields straight from the storage flops
  genvar c;
  generate
    for (c = 0; c < NCONV; c = c + 1)
    begin : g_conv
      assign margin_source_select[c*5 +: 5] =
        conv_words[c*16+`PMC_CONV_SRC_LO +: 5];
      assign margin_loop_stop[c] = conv_words[c*16+`PMC_CONV_LOOP_BIT];
      assign margin_mode[c*2 +: 2] = conv_words[c*16+`PMC_CONV_MM_LO +: 2];
    end
  endgenerate

endmodule

//--- pmc_map.vh
// constants for the pin and margin configuration command handler
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// command codes
`define PMC_CMD_FAULT_LOG   8'hd3
`define PMC_CMD_PIN         8'hd4
`define PMC_CMD_CONV        8'hd5

// element counts
`define PMC_PIN_COUNT       16
`define PMC_CONV_COUNT      9

// block transfer bytes
`define PMC_IDX_ALL         8'hff
`define PMC_RDBK_PLEN       8'h01
`define PMC_WR_MIN          8'h03
`define PMC_PIN_WR_MAX      8'h21
`define PMC_CONV_WR_MAX     8'h13
`define PMC_RD_ONE          8'h02
`define PMC_PIN_RD_ALL      8'h20
`define PMC_CONV_RD_ALL     8'h12

// fault log word
`define PMC_CYCLIC_BIT      0
`define PMC_FAULT_RST       1'b0

// pin word fields
`define PMC_PIN_MODE_HI     15
`define PMC_PIN_MODE_LO     13
`define PMC_PIN_FILT_HI     12
`define PMC_PIN_FILT_LO     9
`define PMC_PIN_DRV_HI      2
`define PMC_PIN_DRV_LO      0
`define PMC_PIN_WMASK       16'hffff
`define PMC_PIN_RST         16'h0000

// pin operating modes
`define PMC_MODE_OUT        3'h1
`define PMC_MODE_IN         3'h2
`define PMC_MODE_INOUT      3'h3

// output driver codes
`define PMC_DRV_WEAK_PD     3'h0
`define PMC_DRV_WEAK_PU     3'h1
`define PMC_DRV_OS_PD       3'h2
`define PMC_DRV_OD_PU       3'h3
`define PMC_DRV_OS          3'h4
`define PMC_DRV_OD          3'h5
`define PMC_DRV_PP          3'h6
`define PMC_DRV_HIZ         3'h7

// converter word fields
`define PMC_CONV_SRC_HI     10
`define PMC_CONV_SRC_LO     6
`define PMC_CONV_LOOP_BIT   5
`define PMC_CONV_MM_HI      1
`define PMC_CONV_MM_LO      0
`define PMC_CONV_WMASK      16'h07ff
`define PMC_CONV_RST        16'h0000

// clock period and glitch filter widths in ns
`define PMC_CLK_NS          4
`define PMC_FILT_NS_0       500
`define PMC_FILT_NS_1       1000
`define PMC_FILT_NS_2       2000
`define PMC_FILT_NS_3       4000
`define PMC_FILT_NS_4       5000
`define PMC_FILT_NS_5       6000
`define PMC_FILT_NS_6       7500
`define PMC_FILT_NS_7       8000
`define PMC_FILT_NS_8       10000
`define PMC_FILT_NS_9       20000
`define PMC_FILT_NS_10      40000
`define PMC_FILT_NS_11      50000
`define PMC_FILT_NS_12      60000
`define PMC_FILT_NS_13      75000
`define PMC_FILT_NS_14      80000
`define PMC_FILT_NS_15      100000

`endif

//--- pmc_cfg_bank.v
// bank of sixteen-bit configuration words with masked writes
`timescale 1ns/10ps
module pmc_cfg_bank #(
  parameter COUNT = 16,
  parameter AW    = 4,
  parameter [15:0] WMASK = 16'hffff,
  parameter [15:0] RST   = 16'h0000
) (
  input  wire                  sys_clk,
  input  wire                  sys_rst,
  input  wire                  wr_en,
  input  wire [AW-1:0]         wr_addr,
  input  wire [15:0]           wr_word,
  input  wire [AW-1:0]         rd_addr,
  output wire [15:0]           rd_word,
  output wire [COUNT*16-1:0]   all_words
);

  reg [15:0] mem_q [0:COUNT-1];   // one word per element
  integer    i;

  ////////////////////////////////////////////////////////////////////////
  // storage; read-only bits are masked off so they always read zero
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (i = 0; i < COUNT; i = i + 1)
        mem_q[i] <= RST;
    end
    else if (wr_en && (wr_addr < COUNT))
    begin
      mem_q[wr_addr] <= wr_word & WMASK;
    end
  end

  // out-of-range reads return zero
  assign rd_word = (rd_addr < COUNT) ? mem_q[rd_addr] : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // flat view of every word for the consumers
  genvar g;
  generate
    for (g = 0; g < COUNT; g = g + 1)
    begin : g_flat
      assign all_words[g*16 +: 16] = mem_q[g];
    end
  endgenerate

endmodule

//--- pmc_pulse_filter.v
// input glitch filter: a level change must persist hold_cycles to pass
`timescale 1ns/10ps
module pmc_pulse_filter #(
  parameter CNT_W = 17
) (
  input  wire             sys_clk,
  input  wire             sys_rst,
  input  wire             raw_in,
  input  wire [CNT_W-1:0] hold_cycles,
  output reg              clean_q
);

  reg [CNT_W-1:0] run_q;   // cycles the raw level has differed

  ////////////////////////////////////////////////////////////////////////
  // any return to the clean level restarts the count, so short pulses die
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      run_q   <= {CNT_W{1'b0}};
      clean_q <= 1'b0;
    end
    else if (raw_in == clean_q)
    begin
      run_q <= {CNT_W{1'b0}};
    end
    else if (run_q + 1'b1 >= hold_cycles)
    begin
      clean_q <= raw_in;
      run_q   <= {CNT_W{1'b0}};
    end
    else
    begin
      run_q <= run_q + 1'b1;
    end
  end

endmodule

//--- pmc_cfg_cmd_sva.sv
// concurrent checks on the ports of the settings command handler
`timescale 1ns/10ps
module pmc_cfg_cmd_sva #(
  parameter NPIN  = 16,
  parameter NCONV = 9
) (
  input wire               sys_clk,
  input wire               sys_rst,
  input wire               cmd_valid,
  input wire               wr_valid,
  input wire               xfer_end,
  input wire               rd_req,
  input wire               rd_valid,
  input wire [7:0]         rd_data,
  input wire               seq_active,
  input wire [NPIN-1:0]    pin_oe,
  input wire [NPIN-1:0]    pin_pull_up,
  input wire [NPIN-1:0]    pin_pull_down,
  input wire               cyclic_record,
  input wire [NCONV*2-1:0] margin_mode,
  input wire [NCONV*5-1:0] margin_source_select,
  input wire [NCONV-1:0]   margin_loop_stop
);
  ////////////////////////////////////////////////////////////
  // single domain: clock and reset given once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // an answer needs a request one cycle before, not killed by stop
  a_rd_cause: assert property (
    rd_valid |-> $past(rd_req) && !$past(xfer_end) && !$past(cmd_valid))
    else $error("read answer without request");
  // returned byte holds between answers; reset edge excluded
  a_rd_hold: assert property (
    !rd_valid && !$past(sys_rst) |-> $stable(rd_data))
    else $error("read byte moved without answer");
  // logging switch only moves after a written byte
  a_log_cause: assert property (
    $changed(cyclic_record) && !$past(sys_rst) |-> $past(wr_valid) || $past(wr_valid, 2))
    else $error("logging switch moved without write");
  // margin outputs follow a write one edge later
  a_mode_cause: assert property (
    $changed(margin_mode) && !$past(sys_rst) |-> $past(wr_valid))
    else $error("margin mode moved without write");
  a_src_cause: assert property (
    $changed(margin_source_select) && !$past(sys_rst) |-> $past(wr_valid))
    else $error("margin source moved without write");
  a_loop_cause: assert property (
    $changed(margin_loop_stop) && !$past(sys_rst) |-> $past(wr_valid))
    else $error("loop behaviour moved without write");
  // no pad is driven while sequencing is stopped
  a_oe_gated: assert property (
    !seq_active [*3] |=> pin_oe == '0)
    else $error("pad driven while sequencing idle");
  // a pin never has both weak pulls on
  a_pull_excl: assert property (
    (pin_pull_up & pin_pull_down) == '0)
    else $error("both pulls on");
  // weak pull-downs are on straight out of reset
  a_rst_pull: assert property (
    $past(sys_rst) && $past(sys_rst, 2) |-> &pin_pull_down && pin_pull_up == '0)
    else $error("reset pulls wrong");
endmodule

bind pmc_cfg_cmd pmc_cfg_cmd_sva #(.NPIN(NPIN), .NCONV(NCONV)) pmc_cfg_cmd_sva_inst (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .wr_valid(wr_valid),
  .xfer_end(xfer_end), .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
  .seq_active(seq_active), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
  .pin_pull_down(pin_pull_down), .cyclic_record(cyclic_record),
  .margin_mode(margin_mode), .margin_source_select(margin_source_select),
  .margin_loop_stop(margin_loop_stop));

//--- pmc_host_model.sv
// host model issuing command, byte, read and stop strobes
`timescale 1ns/10ps
module pmc_host_model (
  input  wire       sys_clk,
  input  wire       slow,
  output reg        cmd_valid,
  output reg  [7:0] cmd_code,
  output reg        wr_valid,
  output reg  [7:0] wr_data,
  output reg        xfer_end,
  output reg        rd_req
);
  initial {cmd_valid, wr_valid, xfer_end, rd_req, cmd_code, wr_data} = 20'h00000;
  ////////////////////////////////////////////////////////////
  // one strobe set per edge; idle lanes invert so stale bytes never pass
  task step(input [3:0] k, input [7:0] b);
    @(posedge sys_clk);
    {cmd_valid, wr_valid, xfer_end, rd_req} <= k;
    cmd_code <= k[3] ? b : ~cmd_code;
    wr_data <= k[2] ? b : ~wr_data;
    // slow host: a gap after every request
    if (slow && k != 4'h0)
    begin
      @(posedge sys_clk);
      {cmd_valid, wr_valid, xfer_end, rd_req} <= 4'h0;
      cmd_code <= ~cmd_code;
      wr_data <= ~wr_data;
    end
  endtask
  task cmd(input [7:0] c);
    step(4'h8, c);
  endtask
  task wr(input [7:0] b);
    step(4'h4, b);
  endtask
  task rd;
    step(4'h1, 8'h00);
  endtask
  // stop, then idle long enough for pad outputs to follow
  task fin;
    step(4'h2, 8'h00);
    step(4'h0, 8'h00);
    step(4'h0, 8'h00);
  endtask
endmodule

//--- tb.sv
// self-checking bench for the settings command handler
`timescale 1ns/10ps
module tb;
  ////////////////////////////////////////////////////////////
  reg         sys_clk = 1'b0, sys_rst = 1'b1, seq_active = 1'b0, slow = 1'b0, lvl, en;
  reg  [15:0] drv_level = 16'h0000, pin_in = 16'h0000;
  wire        cmd_valid, wr_valid, xfer_end, rd_req, rd_valid, cyclic_record;
  wire [7:0]  cmd_code, wr_data, rd_data;
  wire [15:0] pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_in_filt;
  wire [17:0] margin_mode;
  wire [44:0] margin_source_select;
  wire [8:0]  margin_loop_stop;
  integer     errors = 0, n_checks = 0, cyc = 0, seed = 32'h610bd4b1, i, m, d;
  reg  [15:0] pin_w [0:15];  // expected pin words
  reg  [15:0] cv_w [0:8];    // expected converter words
  reg  [15:0] wb [0:15];     // words for the next block write
  reg  [7:0]  exp_q [$];     // expected read bytes, oldest first
  always #2 sys_clk = ~sys_clk;
  pmc_host_model pmc_host_model_inst (.sys_clk(sys_clk), .slow(slow),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_valid(wr_valid),
    .wr_data(wr_data), .xfer_end(xfer_end), .rd_req(rd_req));
  // short filter counts: 500 ns per cycle
  pmc_cfg_cmd #(.CLK_NS(500)) pmc_cfg_cmd_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_valid(wr_valid), .wr_data(wr_data),
    .xfer_end(xfer_end), .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
    .seq_active(seq_active), .drv_level(drv_level), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
    .pin_in_filt(pin_in_filt), .cyclic_record(cyclic_record), .margin_mode(margin_mode),
    .margin_source_select(margin_source_select), .margin_loop_stop(margin_loop_stop));
  ////////////////////////////////////////////////////////////
  task chk(input [63:0] seen, input [63:0] want);
    n_checks = n_checks + 1;
    if (seen !== want)
    begin
      errors = errors + 1;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, far above the run's length
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      errors = errors + 1;
      wrap_up;
    end
  end
  // answers are sampled before this edge lands; a stray one never matches
  always @(posedge sys_clk)
    if (rd_valid === 1'b1)
      chk(rd_data, exp_q.size() ? exp_q.pop_front() : 9'h100);
  ////////////////////////////////////////////////////////////
  // reset held two cycles; expected words back to zero
  task do_rst;
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 16; i = i + 1)
      pin_w[i] = 16'h0000;
    for (i = 0; i < 9; i = i + 1)
      cv_w[i] = 16'h0000;
    @(posedge sys_clk);
    chk(pin_pull_down, 16'hffff);
    chk({pin_pull_up, margin_mode, cyclic_record}, 35'h0);
  endtask
  // block write of (cnt-1)/2 words from wb
  task blk(input [7:0] c, input [7:0] cnt, input [7:0] st);
    integer n, nw, k;
    n = (c == 8'hd4) ? 16 : 9;
    nw = (cnt - 1) / 2;
    slow <= wb[1][2];
    pmc_host_model_inst.cmd(c);
    pmc_host_model_inst.wr(cnt);
    pmc_host_model_inst.wr(st);
    for (k = 0; k < nw; k = k + 1)
    begin
      pmc_host_model_inst.wr(wb[k][7:0]);
      pmc_host_model_inst.wr(wb[k][15:8]);
    end
    pmc_host_model_inst.fin;
    if (cnt >= 3 && cnt <= 2 * n + 1 && st + nw <= n)
      for (k = 0; k < nw; k = k + 1)
        if (n == 16)
          pin_w[st+k] = wb[k];
        else
          cv_w[st+k] = wb[k] & 16'h07ff;
  endtask
  // readback: length 1, index, then length byte and words low first
  task rdb(input [7:0] c, input [7:0] idx);
    integer n, f, len, k;
    reg [15:0] w;
    n = (c == 8'hd4) ? 16 : 9;
    f = (idx < n) ? idx : 0;
    len = (idx == 8'hff) ? 2 * n : (idx < n) ? 2 : 0;
    exp_q.push_back(len[7:0]);
    for (k = 0; k < len / 2; k = k + 1)
    begin
      w = (n == 16) ? pin_w[f+k] : cv_w[f+k];
      exp_q.push_back(w[7:0]);
      exp_q.push_back(w[15:8]);
    end
    pmc_host_model_inst.cmd(c);
    pmc_host_model_inst.wr(8'h01);
    pmc_host_model_inst.wr(idx);
    repeat (len + 1) pmc_host_model_inst.rd;
    pmc_host_model_inst.fin;
  endtask
  task rnd;
    for (i = 0; i < 16; i = i + 1)
      wb[i] = $random(seed);
  endtask
  task cvchk;
    for (i = 0; i < 9; i = i + 1)
    begin
      chk(margin_mode[2*i+:2], cv_w[i][1:0]);
      chk(margin_source_select[5*i+:5], cv_w[i][10:6]);
      chk(margin_loop_stop[i], cv_w[i][5]);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    do_rst;
    // logging switch: only bit 0 counts, upper bits read zero
    wb[0] = 16'hfffe;
    wb[1] = 16'h0001;
    for (m = 0; m < 2; m = m + 1)
    begin
      pmc_host_model_inst.cmd(8'hd3);
      pmc_host_model_inst.wr(wb[m][7:0]);
      pmc_host_model_inst.wr(wb[m][15:8]);
      pmc_host_model_inst.fin;
      chk(cyclic_record, wb[m][0]);
    end
    exp_q.push_back(8'h01);
    exp_q.push_back(8'h00);
    pmc_host_model_inst.cmd(8'hd3);
    pmc_host_model_inst.rd;
    pmc_host_model_inst.rd;
    pmc_host_model_inst.fin;
    // pins: walk, full write, refused writes, readbacks
    rnd;
    blk(8'hd4, 8'h07, 8'h05);
    rdb(8'hd4, 8'h06);
    rnd;
    blk(8'hd4, 8'h21, 8'h00);
    rnd;
    blk(8'hd4, 8'h02, 8'h00);
    blk(8'hd4, 8'h22, 8'h00);
    blk(8'hd4, 8'h05, 8'h0f);
    rdb(8'hd4, 8'hff);
    rdb(8'hd4, 8'h10);
    // converters: full write, margin modes, walk, refused, readbacks
    rnd;
    blk(8'hd5, 8'h13, 8'h00);
    cvchk;
    for (m = 0; m < 4; m = m + 1)
    begin
      wb[0][1:0] = m[1:0];
      blk(8'hd5, 8'h03, 8'h08);
      cvchk;
    end
    rnd;
    blk(8'hd5, 8'h07, 8'h05);
    blk(8'hd5, 8'h14, 8'h00);
    blk(8'hd5, 8'h05, 8'h08);
    cvchk;
    rdb(8'hd5, 8'hff);
    rdb(8'hd5, 8'h08);
    rdb(8'hd5, 8'h09);
    // every pin mode against every driver type on pin 0, sequencing random
    for (m = 0; m < 8; m = m + 1)
      for (d = 0; d < 8; d = d + 1)
      begin
        wb[1] = $random(seed);
        drv_level <= wb[1];
        seq_active <= wb[1][1];
        lvl = wb[1][0];
        wb[0] = {m[2:0], 10'h000, d[2:0]};
        blk(8'hd4, 8'h03, 8'h00);
        en = (m == 1 || m == 3) && wb[1][1];
        chk(pin_oe[0], en & (d == 6 | (d == 2 | d == 4) & lvl | (d == 3 | d == 5) & !lvl));
        chk(pin_out[0], d == 6 ? lvl : (d == 2 | d == 4));
        chk(pin_pull_down[0], d == 0 | d == 2 & en);
        chk(pin_pull_up[0], d == 1 | d == 3 & en);
      end
    seq_active <= 1'b0;
    // input filter of 4 us is eight cycles: a five-cycle pulse is lost
    wb[0] = 16'h4607;
    blk(8'hd4, 8'h03, 8'h01);
    pin_in <= wb[1] | 16'h0002;
    repeat (5) @(posedge sys_clk);
    pin_in <= wb[1] & 16'hfffd;
    repeat (12) @(posedge sys_clk);
    chk(pin_in_filt[1], 1'b0);
    pin_in <= wb[1] | 16'h0002;
    repeat (16) @(posedge sys_clk);
    chk(pin_in_filt[1], 1'b1);
    // read with no open command gets no answer
    pmc_host_model_inst.rd;
    pmc_host_model_inst.fin;
    // second reset in mid-run
    do_rst;
    rdb(8'hd4, 8'hff);
    repeat (4) @(posedge sys_clk);
    chk(exp_q.size(), 0);
    wrap_up;
  end
endmodule
